/* File: verilog/vphy_adv_regs.sv */
// Purpose: emulated phy advertisement and partner ability registers
// Assumes: one-cycle request strobes from the register port, serial frame
//          engine and configuration loader
// Notes:   answers come one cycle after the strobe
//
// Contract
// - upper 16 bits read zero; serial access sees 16-bit word
// - next-page advertisement bit 15 reads zero, not writable
// - remote-fault advertisement bit 13 reads zero, not writable
// - asymmetric and symmetric pause bits 11 and 10 are writable
// - pause bits reset to one if strap low, zero if high
// - strap level captured at reset release and held
// - 100BASE-T4 bit 9 reads zero, not writable
// - 100BASE-X full and half duplex bits 8, 7 writable, reset one
// - 10BASE-T full and half duplex bits 6, 5 writable, reset one
// - strap defaults overwrite the advertisement bits after reset or reload command; loader writes the writable bits
// - partner ability register is read-only with emulated values
// - partner next-page bit 15 always reads zero
// - partner acknowledge bit 14 always reads one
`timescale 1ns/100ps
`default_nettype none
module vphy_adv_regs
  import vphy_adv_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        flow_control_default_strap,
  input  wire logic        reload_cmd,
  input  wire logic        cfg_load_valid,
  input  wire logic [15:0] cfg_load_data,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_ack,
  input  wire logic        mii_wr,
  input  wire logic        mii_rd,
  input  wire logic [4:0]  mii_regad,
  input  wire logic [15:0] mii_wdata,
  output logic [15:0]      mii_rdata,
  output logic             mii_ack,
  output logic [15:0]      advertise_word,
  output logic             defaults_loaded
);

  logic        strap_level;
  logic        strap_valid;
  logic        strap_valid_d;
  logic [15:0] emulated_phy_advertise;
  logic [15:0] next_advertise;
  logic [31:0] next_reg_rdata;
  logic        next_reg_ack;
  logic [15:0] next_mii_rdata;
  logic        next_mii_ack;
  logic        next_defaults_loaded;
  logic [15:0] partner_word;
  logic [15:0] default_word;

  // ==========================================================
  // strap capture
  strap_capture u_strap (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .strap_pin   (flow_control_default_strap),
    .strap_level (strap_level),
    .strap_valid (strap_valid)
  );

  // ==========================================================
  // helpers
  function automatic logic [15:0] keep_fixed(input logic [15:0] old_word,
                                             input logic [15:0] new_word);
    keep_fixed = (old_word & ~ADV_WRITE_MASK) | (new_word & ADV_WRITE_MASK);
  endfunction

  function automatic logic [15:0] read_word(input logic [1:0]  sel,
                                            input logic [15:0] adv,
                                            input logic [15:0] partner);
    case (sel)
      2'h1:    read_word = adv;
      2'h2:    read_word = partner;
      default: read_word = PAD_ZERO;
    endcase
  endfunction

  function automatic logic [1:0] decode_offset(input logic [8:0] addr);
    if (addr == ADV_OFFSET) begin
      decode_offset = 2'h1;
    end else if (addr == PARTNER_OFFSET) begin
      decode_offset = 2'h2;
    end else begin
      decode_offset = 2'h0;
    end
  endfunction

  function automatic logic [1:0] decode_index(input logic [4:0] idx);
    if (idx == ADV_INDEX) begin
      decode_index = 2'h1;
    end else if (idx == PARTNER_INDEX) begin
      decode_index = 2'h2;
    end else begin
      decode_index = 2'h0;
    end
  endfunction

  // ==========================================================
  // default and emulated words
  always_comb begin
    default_word = ADV_RESET_BASE;
    if (!strap_level) begin
      default_word = ADV_RESET_BASE | PAUSE_MASK;
    end
    partner_word = (emulated_phy_advertise & PARTNER_MIRROR) | PARTNER_FIXED;
    partner_word[NEXT_PAGE_BIT] = 1'b0;
    partner_word[ACK_BIT] = 1'b1;
  end

  // ==========================================================
  // advertisement register
  always_comb begin
    next_advertise       = emulated_phy_advertise;
    next_defaults_loaded = defaults_loaded;
    if (strap_valid && !strap_valid_d) begin
      next_advertise       = default_word;
      next_defaults_loaded = 1'b1;
    end else if (reload_cmd) begin
      next_advertise = default_word;
    end else if (cfg_load_valid) begin
      next_advertise = keep_fixed(emulated_phy_advertise, cfg_load_data);
    end else if (reg_wr && decode_offset(reg_addr) == 2'h1) begin
      next_advertise = keep_fixed(emulated_phy_advertise, reg_wdata[15:0]);
    end else if (mii_wr && decode_index(mii_regad) == 2'h1) begin
      next_advertise = keep_fixed(emulated_phy_advertise, mii_wdata);
    end
    next_advertise[NEXT_PAGE_BIT]    = 1'b0;
    next_advertise[ACK_BIT]          = 1'b0;
    next_advertise[REMOTE_FAULT_BIT] = 1'b0;
    next_advertise[RESERVED_BIT]     = 1'b0;
    next_advertise[T4_BIT]           = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      emulated_phy_advertise <= ADV_RESET_BASE | PAUSE_MASK;
      strap_valid_d          <= 1'b0;
      defaults_loaded        <= 1'b0;
      advertise_word         <= ADV_RESET_BASE | PAUSE_MASK;
    end else begin
      emulated_phy_advertise <= next_advertise;
      strap_valid_d          <= strap_valid;
      defaults_loaded        <= next_defaults_loaded;
      advertise_word         <= next_advertise;
    end
  end

  // ==========================================================
  // read answers
  always_comb begin
    next_reg_rdata = reg_rdata;
    next_reg_ack   = reg_rd || reg_wr;
    next_mii_rdata = mii_rdata;
    next_mii_ack   = mii_rd || mii_wr;
    if (reg_rd) begin
      next_reg_rdata = {PAD_ZERO,
                        read_word(decode_offset(reg_addr),
                                  emulated_phy_advertise, partner_word)};
      if (decode_offset(reg_addr) == 2'h0) begin
        next_reg_rdata = UNMAPPED_READ;
      end
    end
    if (mii_rd) begin
      next_mii_rdata = read_word(decode_index(mii_regad),
                                 emulated_phy_advertise, partner_word);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= UNMAPPED_READ;
      reg_ack   <= 1'b0;
      mii_rdata <= PAD_ZERO;
      mii_ack   <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_ack   <= next_reg_ack;
      mii_rdata <= next_mii_rdata;
      mii_ack   <= next_mii_ack;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/vphy_adv_pkg.sv */
// Purpose: constants for the emulated phy advertisement registers
// Assumes: 100 MHz sys_clk, byte offsets on the 32-bit register port
// Notes:   mii index is the register number of the serial frame
package vphy_adv_pkg;

  // ==========================================================
  // register map
  localparam logic [8:0]  ADV_OFFSET       = 9'h1D0;
  localparam logic [8:0]  PARTNER_OFFSET   = 9'h1D4;
  localparam logic [4:0]  ADV_INDEX        = 5'h04;
  localparam logic [4:0]  PARTNER_INDEX    = 5'h05;

  // ==========================================================
  // field positions
  localparam int          NEXT_PAGE_BIT    = 15;
  localparam int          ACK_BIT          = 14;
  localparam int          RESERVED_BIT     = 12;
  localparam int          REMOTE_FAULT_BIT = 13;
  localparam int          ASYM_PAUSE_BIT   = 11;
  localparam int          SYM_PAUSE_BIT    = 10;
  localparam int          T4_BIT           = 9;
  localparam int          TX_FD_BIT        = 8;
  localparam int          TX_HD_BIT        = 7;
  localparam int          T10_FD_BIT       = 6;
  localparam int          T10_HD_BIT       = 5;

  // ==========================================================
  // masks and reset values
  localparam logic [15:0] ADV_WRITE_MASK   = 16'h0DFF;
  localparam logic [15:0] ADV_RESET_BASE   = 16'h01E1;
  localparam logic [15:0] PAUSE_MASK       = 16'h0C00;
  localparam logic [15:0] PARTNER_FIXED    = 16'h4000;
  localparam logic [15:0] PARTNER_MIRROR   = 16'h3FFF;
  localparam logic [15:0] PAD_ZERO         = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

endpackage

/* File: verilog/strap_capture.sv */
// Purpose: synchronise the flow-control strap and hold it after reset release
// Assumes: strap is quasi static, sampled on sys_clk
// Notes:   captured value stands until the next reset
`timescale 1ns/100ps
`default_nettype none
module strap_capture (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic strap_pin,
  output logic      strap_level,
  output logic      strap_valid
);

  logic sync_1;
  logic sync_2;
  logic sync_3;
  logic next_level;
  logic next_valid;

  // ==========================================================
  // three-stage synchroniser
  always_ff @(posedge sys_clk) begin
    sync_1 <= strap_pin;
    sync_2 <= sync_1;
    sync_3 <= sync_2;
  end

  // ==========================================================
  // capture once after release
  always_comb begin
    next_level = strap_level;
    next_valid = strap_valid;
    if (!strap_valid && (sync_2 == sync_3)) begin
      next_level = sync_3;
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_level <= 1'b0;
      strap_valid <= 1'b0;
    end else begin
      strap_level <= next_level;
      strap_valid <= next_valid;
    end
  end

endmodule
`default_nettype wire

/* File: dv/vphy_adv_regs_properties.sv */
// Purpose: port checks for vphy_adv_regs
// Assumes: one-cycle strobes, no two sources in one cycle
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
module vphy_adv_props
  import vphy_adv_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        reload_cmd,
  input wire logic        cfg_load_valid,
  input wire logic [15:0] cfg_load_data,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [8:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        mii_wr,
  input wire logic        mii_rd,
  input wire logic        mii_ack,
  input wire logic [15:0] advertise_word
);
  // ==========================================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic quiet = !reload_cmd && !cfg_load_valid;
  pad_zero_a: assert property (reg_ack |-> reg_rdata[31:16] == 16'h0000)
    else $error("pad bits set");
  fixed_bits_a: assert property ((advertise_word & 16'hF200) == 16'h0000)
    else $error("fixed bits set");
  reg_ack_a: assert property ((reg_rd || reg_wr) |=> reg_ack)
    else $error("reg ack missing");
  mii_ack_a: assert property (mii_rd || mii_wr |=> mii_ack ##1 (mii_ack == $past(mii_rd || mii_wr)))
    else $error("mii ack wrong");
  wr_mask_a: assert property (reg_wr && reg_addr == ADV_OFFSET && quiet |=>
    advertise_word == ($past(reg_wdata[15:0]) & ADV_WRITE_MASK)) else $error("write mask");
  load_mask_a: assert property (cfg_load_valid && !reload_cmd |=>
    advertise_word == ($past(cfg_load_data) & ADV_WRITE_MASK)) else $error("load mask");
  partner_ack_a: assert property (reg_rd && reg_addr == PARTNER_OFFSET |=>
    reg_rdata[15:14] == 2'h1) else $error("partner bits");
  adv_read_a: assert property (reg_rd && reg_addr == ADV_OFFSET && quiet |=>
    reg_rdata[15:0] == $past(advertise_word)) else $error("adv read");
endmodule
bind vphy_adv_regs vphy_adv_props u_props (.*);
`default_nettype wire

/* File: dv/mii_host_model.sv */
// Purpose: management host issuing serial-frame register accesses
// Assumes: strobe one cycle, answer one cycle later
// Notes:   write data is inverted once released
`timescale 1ns/100ps
`default_nettype none
module mii_host_model (
  input  wire logic        sys_clk,
  output logic             mii_wr,
  output logic             mii_rd,
  output logic [4:0]       mii_regad,
  output logic [15:0]      mii_wdata,
  input  wire logic [15:0] mii_rdata,
  input  wire logic        mii_ack
);
  initial begin
    {mii_wr, mii_rd, mii_regad, mii_wdata} = '0;
  end
  // ==========================================================
  // one access, returns unknown without answer
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge sys_clk) #1;
    {mii_wr, mii_rd, mii_regad, mii_wdata} = {w, !w, a, d};
    @(posedge sys_clk) #1;
    {mii_wr, mii_rd, mii_wdata} = {2'h0, ~d};
    q = mii_ack ? mii_rdata : 'x;
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: directed register tests of vphy_adv_regs
// Assumes: 100 MHz clock, strobes driven 1 ns after the edge
// Notes:   strap reset values checked for both levels
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  import vphy_adv_pkg::*;
  logic sys_clk = 1'h0, reset_n = 1'h0, flow_control_default_strap = 1'h0;
  logic reload_cmd = 1'h0, cfg_load_valid = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [15:0] cfg_load_data = 16'h0000, mii_wdata, mii_rdata, advertise_word, q16;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q32;
  logic [8:0]  reg_addr = 9'h0;
  logic [4:0]  mii_regad;
  logic mii_wr, mii_rd, mii_ack, reg_ack, defaults_loaded;
  int n_mismatch = 0, n_compared = 0;
  vphy_adv_regs u_vphy_adv_regs (.*);
  mii_host_model u_mii_host_model (.*);
  always #5 sys_clk = ~sys_clk;
  // ==========================================================
  // access tasks
  task automatic rx(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge sys_clk) #1;
    {reg_wr, reg_rd, reg_wdata} = {2'h0, ~d};
    q32 = reg_ack ? reg_rdata : 'x;
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    rx(1'h0, a, 32'h0);
    `CHK("reg read", e, q32)
  endtask
  task automatic mchk(input logic [4:0] a, input logic [15:0] e);
    u_mii_host_model.xfer(1'h0, a, 16'h0, q16);
    `CHK("mii read", e, q16)
  endtask
  task automatic pulse(input logic ld);
    @(posedge sys_clk) #1;
    {cfg_load_valid, reload_cmd} = {ld, !ld};
    @(posedge sys_clk) #1;
    {cfg_load_valid, reload_cmd} = 2'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset();
    reset_n = 1'h0;
    repeat (20) @(posedge sys_clk);
    #1 reset_n = 1'h1;
    for (int i = 0; i < 20 && defaults_loaded !== 1'h1; i++) @(posedge sys_clk);
    #1;
    `CHK("loaded", 1'h1, defaults_loaded)
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    #5000 n_mismatch++;
    report_and_stop();
  end
  initial begin
    do_reset();
    rchk(ADV_OFFSET, 32'h0000_0DE1);
    rx(1'h1, ADV_OFFSET, 32'hFFFF_FFE1);
    rchk(ADV_OFFSET, 32'h0000_0DE1);
    rx(1'h1, ADV_OFFSET, 32'h0000_0001);
    rchk(ADV_OFFSET, 32'h0000_0001);
    mchk(ADV_INDEX, 16'h0001);
    mchk(PARTNER_INDEX, 16'h4001);
    rx(1'h1, PARTNER_OFFSET, 32'h0000_8000);
    u_mii_host_model.xfer(1'h1, PARTNER_INDEX, 16'h8000, q16);
    rchk(PARTNER_OFFSET, 32'h0000_4001);
    u_mii_host_model.xfer(1'h1, ADV_INDEX, 16'h0C01, q16);
    rchk(ADV_OFFSET, 32'h0000_0C01);
    rchk(9'h1D8, UNMAPPED_READ);
    mchk(5'h1F, PAD_ZERO);
    cfg_load_data = 16'hFBA1;
    pulse(1'h1);
    `CHK("load", 16'h09A1, advertise_word)
    pulse(1'h0);
    `CHK("reload", 16'h0DE1, advertise_word)
    flow_control_default_strap = 1'h1;
    do_reset();
    rchk(ADV_OFFSET, 32'h0000_01E1);
    flow_control_default_strap = 1'h0;
    pulse(1'h0);
    `CHK("held strap", 16'h01E1, advertise_word)
    report_and_stop();
  end
endmodule
`default_nettype wire
